// >>> hw/ulc_regs.svh
`ifndef ULC_REGS_SVH
`define ULC_REGS_SVH
`define ULC_OFS_LINE   5'h00
`define ULC_OFS_RATE   5'h04
`define ULC_OFS_COND   5'h08
`define ULC_OFS_DATA   5'h0C
`define ULC_OFS_ENAB   5'h10
`define ULC_OFS_RTSTH  5'h14
`define ULC_LC_RESET   32'h0000_0230
`define ULC_LC_MASK    32'h0000_0FFF
`define ULC_LC_LEN     5:4
`define ULC_LC_LOOP    6
`define ULC_LC_ISO     7
`define ULC_LC_CTS     8
`define ULC_LC_DEFAULT_REQUEST_LEVEL  9
`define ULC_LC_AUTO_REQUEST_DRIVE 10
`define ULC_LC_OSR8    11
`define ULC_RD_DIVIDER_SIXTY_FOURTHS    5:0
`define ULC_RD_INT     23:6
`define ULC_RD_MASK    32'h00FF_FFFF
`define ULC_EN_RX      0
`define ULC_EN_TX      1
`define ULC_ST_AVAIL   0
`define ULC_ST_ROOM    1
`define ULC_ST_BUSY    2
`define ULC_ST_TO      3
`define ULC_ST_OVR     4
`define ULC_ST_FRM     5
`define ULC_ST_PAR     6
`define ULC_ST_BRK     7
`define ULC_ST_RTS     15
`define ULC_TICKS16    5'h10
`define ULC_TICKS8     5'h08
`define ULC_MIN_BITS   4'h5
`define ULC_MAX_BITS   4'h8
`define ULC_FRAME_XTRA 4'h2
`define ULC_TO_CHARS   4'h4
`endif

// >>> hw/ulc_pkg.sv
package ulc_pkg;
   typedef enum logic [1:0] {
      ulc_idle  = 2'b00,
      ulc_start = 2'b01,
      ulc_data  = 2'b10,
      ulc_stop  = 2'b11
   } ulc_ser_state_t;
   typedef struct packed {
      logic       brk;
      logic       par;
      logic       frm;
      logic [7:0] data;
   } ulc_rx_word_t;
endpackage : ulc_pkg

// >>> hw/ulc_baud_gen.sv
`timescale 1ns/1ns
module ulc_baud_gen (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        restart,
   input  wire logic [17:0] whole,
   input  wire logic [5:0]  sixty_fourths,
   output logic             tick
);
   import ulc_pkg::*;
   typedef struct packed {
      logic [17:0] cnt;
      logic [5:0]  acc;
      logic        tick;
   } ulc_div_state_t;
   ulc_div_state_t s_reg;
   ulc_div_state_t s_next;
   logic [6:0]     sum;
   always_comb begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      sum = {1'b0, s_reg.acc} + {1'b0, sixty_fourths};
      if (restart) begin
         s_next = '0;
      end else if (whole != 18'h0) begin
         if (s_reg.cnt == 18'h0) begin
            s_next.tick = 1'b1;
            s_next.acc = sum[5:0];
            // Carry out of the fraction stretches this period by one clock
            s_next.cnt = whole - 18'h1 + {17'h0, sum[6]};
         end else begin
            s_next.cnt = s_reg.cnt - 18'h1;
         end
      end
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) s_reg <= '0;
      else s_reg <= s_next;
   end
   assign tick = s_reg.tick;
endmodule : ulc_baud_gen

// >>> hw/ulc_rx_fifo.sv
`timescale 1ns/1ns
module ulc_rx_fifo #(
   parameter int  DEPTH = 16,
   localparam int AW    = $clog2(DEPTH)
) (
   input  wire logic                  sys_clk,
   input  wire logic                  rstn,
   input  wire logic                  push,
   input  wire ulc_pkg::ulc_rx_word_t push_word,
   input  wire logic                  pop,
   output ulc_pkg::ulc_rx_word_t      head_word,
   output logic [AW:0]                count,
   output logic                       full,
   output logic                       empty
);
   import ulc_pkg::*;
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("ulc_rx_fifo: DEPTH must be a power of two, at least 2");
   end
   typedef struct packed {
      ulc_rx_word_t [DEPTH-1:0] mem;
      logic [AW-1:0]            wr;
      logic [AW-1:0]            rd;
      logic [AW:0]              cnt;
   } ulc_fifo_state_t;
   ulc_fifo_state_t f_reg;
   ulc_fifo_state_t f_next;
   logic            do_push;
   logic            do_pop;
   always_comb begin
      f_next = f_reg;
      do_push = push & ~full;
      do_pop = pop & ~empty;
      if (do_push) begin
         f_next.mem[f_reg.wr] = push_word;
         f_next.wr = f_reg.wr + 1'b1;
      end
      if (do_pop) f_next.rd = f_reg.rd + 1'b1;
      f_next.cnt = f_reg.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) f_reg <= '0;
      else f_reg <= f_next;
   end
   assign head_word = f_reg.mem[f_reg.rd];
   assign count = f_reg.cnt;
   assign full = (f_reg.cnt == (AW+1)'(DEPTH));
   assign empty = (f_reg.cnt == '0);
endmodule : ulc_rx_fifo

// >>> hw/ulc_top.sv
`timescale 1ns/1ns
`include "ulc_regs.svh"
module ulc_top #(
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        tx_valid,
   input  wire logic [7:0]  tx_data,
   output logic             tx_ready,
   input  wire logic        rx_line,
   input  wire logic        clear_to_send_n,
   output logic             tx_line,
   output logic             request_to_send_n
);
   import ulc_pkg::*;
   localparam int AW = $clog2(FIFO_DEPTH);
   if (FIFO_DEPTH > 256) begin : g_bad_depth
      $error("ulc_top: FIFO_DEPTH above 256 is not supported");
   end
   typedef struct packed {
      logic [31:0]    lc;
      logic [31:0]    rd;
      logic [1:0]     en;
      logic [AW:0]    thr;
      logic           done;
      logic [31:0]    rdata;
      logic           rx_s1;
      logic           rx_s2;
      logic           cts_s1;
      logic           cts_s2;
      logic           rx_last;
      ulc_ser_state_t rx_st;
      logic [4:0]     rx_tk;
      logic [2:0]     rx_bit;
      logic [7:0]     rx_sh;
      ulc_ser_state_t tx_st;
      logic [4:0]     tx_tk;
      logic [2:0]     tx_bit;
      logic [7:0]     tx_sh;
      logic           tx_int;
      logic           ovr;
      logic [9:0]     to_cnt;
      logic           to_flag;
      logic           tx_pin;
      logic           rts_pin;
   } ulc_top_state_t;
   ulc_top_state_t r_reg;
   ulc_top_state_t r_next;
   logic           req;
   logic           fin;
   logic           restart;
   logic           baud_tick;
   logic           loop_iso;
   logic           rx_in;
   logic           cts_eff;
   logic           rts_int;
   logic           push;
   logic           pop;
   logic           full;
   logic           empty;
   logic [AW:0]    count;
   ulc_rx_word_t   head;
   ulc_rx_word_t   word;
   logic [4:0]     osr;
   logic [4:0]     half;
   logic [3:0]     data_bits;
   logic [2:0]     nbits_m1;
   logic [9:0]     to_limit;
   logic [31:0]    status;
   logic [31:0]    wm;

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      return (old & ~m) | (wd & m);
   endfunction : wmerge

   // One wait state on every access keeps read data a registered value
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~r_reg.done;
   assign fin = req & r_reg.done;
   assign avs_readdata = r_reg.rdata;
   assign restart = fin & avs_write & (avs_address == `ULC_OFS_RATE);

   assign osr = r_reg.lc[`ULC_LC_OSR8] ? `ULC_TICKS8 : `ULC_TICKS16;
   assign half = osr >> 1;
   assign data_bits = `ULC_MIN_BITS + {2'b00, r_reg.lc[`ULC_LC_LEN]};
   assign nbits_m1 = 3'(data_bits - 4'h1);
   assign to_limit = 10'(`ULC_TO_CHARS) * 10'(data_bits + `ULC_FRAME_XTRA) * 10'(osr);

   assign loop_iso = r_reg.lc[`ULC_LC_LOOP] & r_reg.lc[`ULC_LC_ISO];
   assign rx_in = r_reg.lc[`ULC_LC_LOOP] ? r_reg.tx_int : r_reg.rx_s2;
   // Both lines are active low, so the looped level passes straight across
   assign cts_eff = r_reg.lc[`ULC_LC_LOOP] ? rts_int : r_reg.cts_s2;
   assign rts_int = (r_reg.lc[`ULC_LC_AUTO_REQUEST_DRIVE] & r_reg.en[`ULC_EN_RX]) ?
                    (count >= r_reg.thr) : r_reg.lc[`ULC_LC_DEFAULT_REQUEST_LEVEL];
   assign tx_ready = (r_reg.tx_st == ulc_idle) & r_reg.en[`ULC_EN_TX] &
                     ~(r_reg.lc[`ULC_LC_CTS] & cts_eff);
   assign wm = wmerge(r_reg.lc, avs_writedata, avs_byteenable);

   always_comb begin
      status = '0;
      status[`ULC_ST_AVAIL] = ~empty;
      status[`ULC_ST_ROOM] = ~full;
      status[`ULC_ST_BUSY] = (r_reg.rx_st != ulc_idle);
      status[`ULC_ST_TO] = r_reg.to_flag;
      status[`ULC_ST_OVR] = r_reg.ovr;
      status[`ULC_ST_FRM] = head.frm & ~empty;
      status[`ULC_ST_PAR] = head.par & ~empty;
      status[`ULC_ST_BRK] = head.brk & ~empty;
      status[`ULC_ST_RTS] = r_reg.rts_pin;
   end

   always_comb begin
      r_next = r_reg;
      push = 1'b0;
      word = '0;
      pop = fin & avs_read & (avs_address == `ULC_OFS_DATA) & ~empty;
      r_next.done = req & ~r_reg.done;
      r_next.rx_s1 = rx_line;
      r_next.rx_s2 = r_reg.rx_s1;
      r_next.cts_s1 = clear_to_send_n;
      r_next.cts_s2 = r_reg.cts_s1;
      r_next.tx_pin = loop_iso ? 1'b1 : r_reg.tx_int;
      r_next.rts_pin = loop_iso ? r_reg.lc[`ULC_LC_DEFAULT_REQUEST_LEVEL] : rts_int;
      if (req & ~r_reg.done) begin
         unique case (avs_address)
            `ULC_OFS_LINE:  r_next.rdata = r_reg.lc;
            `ULC_OFS_RATE:  r_next.rdata = r_reg.rd;
            `ULC_OFS_COND:  r_next.rdata = status;
            `ULC_OFS_DATA:  r_next.rdata = {24'h0, empty ? 8'h00 : head.data};
            `ULC_OFS_ENAB:  r_next.rdata = {30'h0, r_reg.en};
            `ULC_OFS_RTSTH: r_next.rdata = 32'(r_reg.thr);
            default:        r_next.rdata = '0;
         endcase
      end
      if (fin & avs_write) begin
         unique case (avs_address)
            `ULC_OFS_LINE:  r_next.lc = wm & `ULC_LC_MASK;
            `ULC_OFS_RATE:  r_next.rd = wmerge(r_reg.rd, avs_writedata, avs_byteenable) &
                                        `ULC_RD_MASK;
            `ULC_OFS_ENAB:  r_next.en = avs_byteenable[0] ? avs_writedata[1:0] : r_reg.en;
            `ULC_OFS_RTSTH: r_next.thr = avs_byteenable[0] ? avs_writedata[AW:0] : r_reg.thr;
            default:        r_next.en = r_reg.en;
         endcase
      end
      if (fin & avs_read & (avs_address == `ULC_OFS_COND)) r_next.ovr = 1'b0;

      if (baud_tick) begin
         r_next.rx_last = rx_in;
         unique case (r_reg.rx_st)
            ulc_idle: begin
               // A disabled receiver never leaves idle
               if (r_reg.en[`ULC_EN_RX] && r_reg.rx_last && !rx_in) begin
                  r_next.rx_st = ulc_start;
                  r_next.rx_tk = '0;
               end
            end
            ulc_start: begin
               r_next.rx_tk = r_reg.rx_tk + 5'h1;
               if (r_reg.rx_tk == half - 5'h1) begin
                  r_next.rx_tk = '0;
                  r_next.rx_bit = '0;
                  // Line back high at mid start bit is a glitch
                  r_next.rx_st = rx_in ? ulc_idle : ulc_data;
               end
            end
            ulc_data: begin
               r_next.rx_tk = r_reg.rx_tk + 5'h1;
               if (r_reg.rx_tk == osr - 5'h1) begin
                  r_next.rx_tk = '0;
                  r_next.rx_sh = {rx_in, r_reg.rx_sh[7:1]};
                  r_next.rx_bit = r_reg.rx_bit + 3'h1;
                  if (r_reg.rx_bit == nbits_m1) r_next.rx_st = ulc_stop;
               end
            end
            ulc_stop: begin
               r_next.rx_tk = r_reg.rx_tk + 5'h1;
               if (r_reg.rx_tk == osr - 5'h1) begin
                  // Idle count back to zero so a later rate change cannot strand it
                  r_next.rx_tk = '0;
                  r_next.rx_st = ulc_idle;
                  push = 1'b1;
                  word.data = r_reg.rx_sh >> (`ULC_MAX_BITS - data_bits);
                  word.frm = ~rx_in;
                  word.brk = ~rx_in & (word.data == 8'h00);
               end
            end
         endcase
      end
      if (push & full) r_next.ovr = 1'b1;

      if (tx_valid & tx_ready) begin
         r_next.tx_st = ulc_start;
         r_next.tx_sh = tx_data;
         r_next.tx_tk = '0;
         r_next.tx_int = 1'b0;
      end else if (baud_tick) begin
         unique case (r_reg.tx_st)
            ulc_idle: r_next.tx_int = 1'b1;
            ulc_start: begin
               r_next.tx_tk = r_reg.tx_tk + 5'h1;
               if (r_reg.tx_tk == osr - 5'h1) begin
                  r_next.tx_tk = '0;
                  r_next.tx_bit = '0;
                  r_next.tx_int = r_reg.tx_sh[0];
                  r_next.tx_sh = {1'b0, r_reg.tx_sh[7:1]};
                  r_next.tx_st = ulc_data;
               end
            end
            ulc_data: begin
               r_next.tx_tk = r_reg.tx_tk + 5'h1;
               if (r_reg.tx_tk == osr - 5'h1) begin
                  r_next.tx_tk = '0;
                  r_next.tx_bit = r_reg.tx_bit + 3'h1;
                  r_next.tx_int = r_reg.tx_sh[0];
                  r_next.tx_sh = {1'b0, r_reg.tx_sh[7:1]};
                  if (r_reg.tx_bit == nbits_m1) begin
                     r_next.tx_int = 1'b1;
                     r_next.tx_st = ulc_stop;
                  end
               end
            end
            ulc_stop: begin
               r_next.tx_tk = r_reg.tx_tk + 5'h1;
               if (r_reg.tx_tk == osr - 5'h1) begin
                  r_next.tx_tk = '0;
                  r_next.tx_st = ulc_idle;
               end
            end
         endcase
      end

      if ((push & ~full) | pop | empty) begin
         r_next.to_cnt = '0;
         r_next.to_flag = 1'b0;
      end else begin
         if (baud_tick && r_reg.to_cnt != to_limit) r_next.to_cnt = r_reg.to_cnt + 10'h1;
         if (r_reg.to_cnt == to_limit) r_next.to_flag = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         r_reg <= '0;
         r_reg.lc <= `ULC_LC_RESET;
         r_reg.rx_s1 <= 1'b1;
         r_reg.rx_s2 <= 1'b1;
         r_reg.cts_s1 <= 1'b1;
         r_reg.cts_s2 <= 1'b1;
         r_reg.rx_last <= 1'b1;
         r_reg.tx_int <= 1'b1;
         r_reg.tx_pin <= 1'b1;
         r_reg.rts_pin <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end
   assign tx_line = r_reg.tx_pin;
   assign request_to_send_n = r_reg.rts_pin;

   ulc_baud_gen u_baud (
      .sys_clk       (sys_clk),
      .rstn          (rstn),
      .restart       (restart),
      .whole         (r_reg.rd[`ULC_RD_INT]),
      .sixty_fourths (r_reg.rd[`ULC_RD_DIVIDER_SIXTY_FOURTHS]),
      .tick          (baud_tick)
   );

   ulc_rx_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .push      (push),
      .push_word (word),
      .pop       (pop),
      .head_word (head),
      .count     (count),
      .full      (full),
      .empty     (empty)
   );

   default clocking dcb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   chk_char_len:
   assert property ((r_reg.rx_st == ulc_data) && baud_tick && (r_reg.rx_tk == osr - 5'h1)
                    && (r_reg.rx_bit == nbits_m1) |=> (r_reg.rx_st == ulc_stop))
      else $error("receiver ran past the character length");
   chk_echo_path:
   assert property (r_reg.lc[`ULC_LC_LOOP] && baud_tick && r_reg.en[`ULC_EN_RX] && r_reg.rx_last
                    && !r_reg.tx_int && r_reg.rx_st == ulc_idle |=> r_reg.rx_st == ulc_start)
      else $error("echo path does not follow the transmitter");
   chk_iso_pins:
   assert property (loop_iso |=> tx_line && (request_to_send_n == $past(r_reg.lc[`ULC_LC_DEFAULT_REQUEST_LEVEL])))
      else $error("isolated echo did not idle the pins");
   chk_send_gate:
   assert property (r_reg.lc[`ULC_LC_CTS] && cts_eff |-> !tx_ready)
      else $error("transmit start not held by clear to send");
   chk_rts_default:
   assert property (!loop_iso && !(r_reg.lc[`ULC_LC_AUTO_REQUEST_DRIVE] && r_reg.en[`ULC_EN_RX])
                    |=> request_to_send_n == $past(r_reg.lc[`ULC_LC_DEFAULT_REQUEST_LEVEL]))
      else $error("request line not at default level");
   chk_rts_auto:
   assert property (!loop_iso && r_reg.lc[`ULC_LC_AUTO_REQUEST_DRIVE] && r_reg.en[`ULC_EN_RX]
                    |=> request_to_send_n == $past(count >= r_reg.thr))
      else $error("request line does not follow the threshold");
   chk_tick_range:
   assert property (r_reg.rx_tk < osr && r_reg.tx_tk < osr)
      else $error("oversample counter beyond ticks per bit");
   chk_div_restart:
   assert property (restart |=> !baud_tick ##1 (baud_tick || r_reg.rd[`ULC_RD_INT] == 18'h0))
      else $error("divider not restarted by a write");
   chk_head_flags:
   assert property (empty |-> status[7:5] == 3'h0)
      else $error("error flags shown without a waiting word");
   chk_overflow_set:
   assert property (push && full |=> r_reg.ovr)
      else $error("dropped word not flagged");
   chk_timeout_clear:
   assert property ((push && !full) || pop || empty |=> !r_reg.to_flag && r_reg.to_cnt == 10'h0)
      else $error("timeout not restarted by activity");
   chk_bus_answer:
   assert property (req |-> ##[0:1] !avs_waitrequest)
      else $error("bus request not answered in time");
   cov_break_word: cover property (push && word.brk);
   cov_idle_timeout: cover property ($rose(r_reg.to_flag));
   cov_overflow: cover property (push && full);
   cov_echo_word: cover property (r_reg.lc[`ULC_LC_LOOP] && push && !word.frm);
endmodule : ulc_top

// >>> dv/ulc_remote.sv
`timescale 1ns/1ns
module ulc_remote (
   input  wire logic       sys_clk,
   input  wire logic [7:0] bit_clks,
   input  wire logic [3:0] nbits,
   input  wire logic       tx_line,
   input  wire logic       cts_hold,
   output logic            rx_line,
   output logic            clear_to_send_n,
   output logic            got,
   output logic [7:0]      got_data
);
   assign clear_to_send_n = cts_hold;
   initial begin
      rx_line  = 1'b1;
      got      = 1'b0;
      got_data = 8'h00;
   end
   // Ends on an idle bit, so back-to-back calls never drive the line twice in one step
   task automatic send(input logic [7:0] d, input logic stop);
      for (int i = -1; i <= int'(nbits) + 1; i++) begin
         rx_line <= (i < 0) ? 1'b0 : (i < nbits) ? d[i] : (i == nbits) ? stop : 1'b1;
         repeat (bit_clks) @(posedge sys_clk);
      end
   endtask : send
   // Mid-bit sampling tolerates the fractional jitter of the sender
   initial forever begin
      logic [7:0] v;
      @(negedge tx_line);
      v = 8'h00;
      repeat (bit_clks / 2) @(posedge sys_clk);
      for (int i = 0; i < nbits; i++) begin
         repeat (bit_clks) @(posedge sys_clk);
         v[i] = tx_line;
      end
      repeat (bit_clks) @(posedge sys_clk);
      got_data <= v;
      got      <= tx_line;
      @(posedge sys_clk);
      got      <= 1'b0;
   end
endmodule : ulc_remote

// >>> dv/tb_ulc_top.sv
`timescale 1ns/1ns
`include "ulc_regs.svh"
module tb_ulc_top;
   localparam logic [31:0] ALL_M = 32'hFFFF_FFFF;
   logic        sys_clk;
   logic        rstn;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        tx_valid;
   logic [7:0]  tx_data;
   logic        tx_ready;
   logic        rx_line;
   logic        clear_to_send_n;
   logic        tx_line;
   logic        request_to_send_n;
   logic        cts_hold;
   logic        got;
   logic [7:0]  got_data;
   logic [7:0]  bit_clks;
   logic [3:0]  nbits;
   logic [7:0]  d;
   logic [63:0] reg_q[$];
   logic [7:0]  ser_q[$];
   int          mismatches;
   int          total_checks;
   ulc_top #(.FIFO_DEPTH(2)) uut (
      .sys_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .tx_valid, .tx_data,
      .tx_ready, .rx_line, .clear_to_send_n, .tx_line, .request_to_send_n
   );
   ulc_remote remote (
      .sys_clk, .bit_clks, .nbits, .tx_line, .cts_hold, .rx_line,
      .clear_to_send_n, .got, .got_data
   );
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic final_report;
      if (mismatches == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   task automatic hang;
      mismatches++;
      final_report();
   endtask : hang
   task automatic cmp_reg(input logic [31:0] g, input logic [63:0] note);
      total_checks++;
      if ((g & note[31:0]) !== note[63:32]) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, g & note[31:0], note[63:32]);
      end
   endtask : cmp_reg
   task automatic cmp_ser(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp_ser
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v,
                      input logic [31:0] m);
      int n;
      @(posedge sys_clk);
      avs_address   <= a;
      avs_writedata <= v;
      avs_read      <= ~w;
      avs_write     <= w;
      if (!w)
         reg_q.push_back({v, m});
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
         hang();
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
      bus(1'b0, a, e, m);
   endtask : rd
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      bus(1'b1, a, v, 32'h0000_0000);
   endtask : wr
   // Note off: the word must not reach the pin at all
   task automatic send_tx(input logic [7:0] v, input logic note);
      int n;
      @(posedge sys_clk);
      tx_valid <= 1'b1;
      tx_data  <= v;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge sys_clk);
            n++;
         end while (tx_ready !== 1'b1 && n < 4000);
         if (n >= 4000)
            hang();
         if (k == 0 && note)
            ser_q.push_back(v & (8'hFF >> (8 - nbits)));
         tx_valid <= 1'b0;
      end
   endtask : send_tx
   // Nearest sixty-fourth of the clocks per tick
   function automatic logic [31:0] rate_val(input int clks, input int osr);
      return 32'(((clks * 128) / osr + 1) / 2);
   endfunction : rate_val
   always @(posedge sys_clk)
      if (avs_read && avs_waitrequest === 1'b0)
         cmp_reg(avs_readdata, reg_q.pop_front());
   always @(posedge sys_clk)
      if (got)
         cmp_ser(got_data, ser_q.size() > 0 ? ser_q.pop_front() : 8'hXX);
   initial begin
      repeat (90000) @(posedge sys_clk);
      hang();
   end
   initial begin
      rstn = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      tx_valid = 1'b0;
      tx_data = 8'h00;
      cts_hold = 1'b0;
      bit_clks = 8'h14;
      nbits = 4'h8;
      mismatches = 0;
      total_checks = 0;
      void'($urandom(32'hA12F726A));
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      rd(`ULC_OFS_LINE, 32'h0000_0230, 32'h0000_0FFF);
      rd(`ULC_OFS_RATE, 32'h0000_0000, ALL_M);
      rd(`ULC_OFS_COND, 32'h0000_8002, 32'h0000_80FF);
      rd(5'h1C, 32'h0000_0000, ALL_M);
      wr(`ULC_OFS_RATE, rate_val(20, 8));
      wr(`ULC_OFS_ENAB, 32'h0000_0003);
      for (int c = 0; c < 4; c++) begin
         bit_clks = c[0] ? 8'h14 : 8'h28;
         nbits = 4'(5 + c);
         wr(`ULC_OFS_LINE, {20'h0, c[0], 2'b01, 3'b000, c[1:0], 4'h0});
         d = 8'($urandom);
         fork
            remote.send(d, 1'b1);
            send_tx(~d, 1'b1);
         join
         rd(`ULC_OFS_COND, 32'h0000_0001, 32'h0000_00E1);
         rd(`ULC_OFS_DATA, {24'h0, d & (8'hFF >> (8 - nbits))}, ALL_M);
      end
      fork
         remote.send(8'h5A, 1'b0);
         begin
            repeat (60) @(posedge sys_clk);
            rd(`ULC_OFS_COND, 32'h0000_0004, 32'h0000_0004);
         end
      join
      rd(`ULC_OFS_COND, 32'h0000_0021, 32'h0000_00E1);
      rd(`ULC_OFS_DATA, 32'h0000_005A, ALL_M);
      remote.send(8'h00, 1'b0);
      rd(`ULC_OFS_COND, 32'h0000_00A1, 32'h0000_00E1);
      rd(`ULC_OFS_DATA, 32'h0000_0000, ALL_M);
      rd(`ULC_OFS_COND, 32'h0000_0000, 32'h0000_00E1);
      remote.send(8'h11, 1'b1);
      remote.send(8'h22, 1'b1);
      rd(`ULC_OFS_COND, 32'h0000_0001, 32'h0000_0013);
      remote.send(8'h33, 1'b1);
      rd(`ULC_OFS_COND, 32'h0000_0011, 32'h0000_0013);
      rd(`ULC_OFS_COND, 32'h0000_0001, 32'h0000_0013);
      rd(`ULC_OFS_DATA, 32'h0000_0011, ALL_M);
      rd(`ULC_OFS_DATA, 32'h0000_0022, ALL_M);
      rd(`ULC_OFS_COND, 32'h0000_0002, 32'h0000_0013);
      // Four characters of ten bits are 800 clocks at this rate
      remote.send(8'h44, 1'b1);
      repeat (700) @(posedge sys_clk);
      rd(`ULC_OFS_COND, 32'h0000_0001, 32'h0000_0009);
      repeat (200) @(posedge sys_clk);
      rd(`ULC_OFS_COND, 32'h0000_0009, 32'h0000_0009);
      rd(`ULC_OFS_DATA, 32'h0000_0044, ALL_M);
      rd(`ULC_OFS_COND, 32'h0000_0000, 32'h0000_0009);
      wr(`ULC_OFS_RTSTH, 32'h0000_0001);
      wr(`ULC_OFS_LINE, 32'h0000_0E30);
      rd(`ULC_OFS_COND, 32'h0000_0000, 32'h0000_8000);
      remote.send(8'h55, 1'b1);
      rd(`ULC_OFS_COND, 32'h0000_8001, 32'h0000_8001);
      rd(`ULC_OFS_DATA, 32'h0000_0055, ALL_M);
      wr(`ULC_OFS_ENAB, 32'h0000_0002);
      rd(`ULC_OFS_COND, 32'h0000_8000, 32'h0000_8001);
      remote.send(8'h66, 1'b1);
      rd(`ULC_OFS_COND, 32'h0000_8000, 32'h0000_8001);
      wr(`ULC_OFS_ENAB, 32'h0000_0003);
      cts_hold <= 1'b1;
      wr(`ULC_OFS_LINE, 32'h0000_0970);
      d = 8'($urandom);
      send_tx(d, 1'b1);
      rd(`ULC_OFS_DATA, {24'h0, d}, ALL_M);
      wr(`ULC_OFS_LINE, 32'h0000_0EF0);
      rd(`ULC_OFS_COND, 32'h0000_8000, 32'h0000_8000);
      send_tx(~d, 1'b0);
      rd(`ULC_OFS_DATA, {24'h0, ~d}, ALL_M);
      wr(`ULC_OFS_LINE, 32'h0000_0B30);
      fork
         send_tx(d, 1'b1);
         begin
            repeat (100) @(posedge sys_clk);
            cmp_ser({5'h00, request_to_send_n, tx_ready, tx_line}, 8'h05);
            cts_hold <= 1'b0;
         end
      join
      repeat (20) @(posedge sys_clk);
      cmp_ser(8'(ser_q.size()), 8'h00);
      final_report();
   end
endmodule : tb_ulc_top
